// File: design/srr_pkg.sv
// Shared constants and carrier types of the security area read block.
package srr_pkg;

  localparam logic [7:0] CMD_RD_SEC = 8'h48;
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h1F;
  localparam logic [5:0] DUMMY_LAST_BIT = 6'h27;
  localparam int SEC_AW = 10;
  localparam int SEC_BYTES = 1024;
  localparam logic [SEC_AW-1:0] SEC_LAST = 10'h3FF;
  localparam logic [SEC_AW-1:0] SEC_FIRST = 10'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] STATUS_DELIVERY = 8'h00;
  localparam int BUF_DEPTH = 2;

  localparam int MCLK_MHZ = 200;
  localparam int PUW_US = 10000;
  localparam int PUW_CYCLES = PUW_US * MCLK_MHZ;
  localparam int PU_CW = 22;

  typedef enum logic [2:0] {S_CMD, S_ADDR, S_DUMMY, S_DATA, S_SKIP} srr_state_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } srr_pin_in_s;

  typedef struct packed {
    logic so;
    logic so_oe;
  } srr_pin_out_s;

  typedef struct packed {
    logic valid;
    logic [SEC_AW-1:0] addr;
    logic [7:0] data;
  } srr_prog_s;

  typedef struct packed {
    logic [2:0] sclk_sy;
    logic [1:0] cs_sy;
    logic [1:0] si_sy;
    srr_state_e state;
    logic [5:0] bit_cnt;
    logic [7:0] in_sh;
    logic [SEC_AW-1:0] addr_sh;
    logic [SEC_AW-1:0] fptr;
    logic fetching;
    logic pend;
    logic [2:0] out_idx;
    logic [7:0] out_sh;
    logic so;
    logic so_oe;
    logic [PU_CW-1:0] pu_cnt;
    logic pu_done;
    logic [7:0] status;
    logic any_prog;
  } srr_core_s;

endpackage

// File: design/srr_top.sv
// Security area read engine of a serial flash with its prefetch buffer.
`timescale 1ns/1ps

module srr_buf2 #(
  parameter int W = 8,
  parameter int D = 2
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] ent;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } srr_buf_s;

  srr_buf_s b_reg;
  srr_buf_s b_next;
  logic push;
  logic pop;

  assign in_ready = (b_reg.cnt != (PW+1)'(D));
  assign out_valid = (b_reg.cnt != '0);
  assign out_data = b_reg.ent[b_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    b_next = b_reg;
    if (push)
    begin
      b_next.ent[b_reg.wp] = in_data;
      b_next.wp = (b_reg.wp == PW'(D-1)) ? '0 : b_reg.wp + 1'b1;
    end
    if (pop)
    begin
      b_next.rp = (b_reg.rp == PW'(D-1)) ? '0 : b_reg.rp + 1'b1;
    end
    b_next.cnt = b_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (flush)
    begin
      b_next.wp = '0;
      b_next.rp = '0;
      b_next.cnt = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      b_reg <= '0;
    else
      b_reg <= b_next;
  end
endmodule

module srr_top #(
  parameter int PU_CYCLES = srr_pkg::PUW_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Serial pins.
  input wire srr_pkg::srr_pin_in_s pin_in,
  output srr_pkg::srr_pin_out_s pin_out,
  // Factory programming port.
  input wire srr_pkg::srr_prog_s prog,
  output logic prog_ready,
  // Status.
  output logic [7:0] status_byte
);
  import srr_pkg::*;

  srr_core_s st_reg;
  srr_core_s st_next;
  logic [7:0] sec_mem [SEC_BYTES];
  logic [7:0] mem_q;
  logic rise;
  logic fall;
  logic selected;
  logic prog_fire;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic push;

  assign rise = st_reg.sclk_sy[1] && !st_reg.sclk_sy[2];
  assign fall = !st_reg.sclk_sy[1] && st_reg.sclk_sy[2];
  assign selected = !st_reg.cs_sy[1];
  // Programming is refused while the host has the part selected.
  // write inhibit
  assign prog_ready = st_reg.pu_done && !selected;
  assign prog_fire = prog.valid && prog_ready;
  assign push = st_reg.pend && buf_in_ready;
  assign buf_out_ready = selected && fall && st_reg.state == S_DATA
    && st_reg.out_idx == 3'h0;
  assign pin_out.so = st_reg.so;
  assign pin_out.so_oe = st_reg.so_oe;
  assign status_byte = st_reg.status;

  initial
  begin
    for (int i = 0; i < SEC_BYTES; i++)
      sec_mem[i] = ERASED_BYTE;
  end

  // Programming can only clear bits, as in the real array.
  // A plain clocked process, since the erased image is loaded at start.
  always @(posedge mclk)
  begin
    mem_q <= sec_mem[st_reg.fptr];
    if (prog_fire)
      sec_mem[prog.addr] <= sec_mem[prog.addr] & prog.data;
  end

  srr_buf2 #(
    .W(8),
    .D(BUF_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .rstn(rstn),
    .flush(!selected),
    .in_valid(st_reg.pend),
    .in_ready(buf_in_ready),
    .in_data(mem_q),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  always_comb
  begin
    st_next = st_reg;
    st_next.sclk_sy = {st_reg.sclk_sy[1:0], pin_in.sclk};
    st_next.cs_sy = {st_reg.cs_sy[0], pin_in.cs_n};
    st_next.si_sy = {st_reg.si_sy[0], pin_in.si};
    if (!st_reg.pu_done)
    begin
      st_next.pu_cnt = st_reg.pu_cnt + 1'b1;
      st_next.pu_done = (st_reg.pu_cnt == PU_CW'(PU_CYCLES - 1));
    end
    if (prog_fire)
      st_next.any_prog = 1'b1;
    // Prefetch keeps the buffer full ahead of the shifter.
    if (st_reg.fetching && !st_reg.pend)
      st_next.pend = 1'b1;
    if (push)
    begin
      st_next.pend = 1'b0;
      st_next.fptr = st_reg.fptr + 1'b1;
    end
    if (!selected)
    begin
      st_next.state = S_CMD;
      st_next.bit_cnt = '0;
      st_next.so_oe = 1'b0;
      st_next.fetching = 1'b0;
      st_next.pend = 1'b0;
      st_next.out_idx = '0;
    end
    else if (rise)
    begin
      st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
      st_next.in_sh = {st_reg.in_sh[6:0], st_reg.si_sy[1]};
      case (st_reg.state)
        S_CMD:
        begin
          if (st_reg.bit_cnt == CMD_LAST_BIT)
            st_next.state = ({st_reg.in_sh[6:0], st_reg.si_sy[1]}
              == CMD_RD_SEC) ? S_ADDR : S_SKIP;
        end
        S_ADDR:
        begin
          st_next.addr_sh = {st_reg.addr_sh[SEC_AW-2:0], st_reg.si_sy[1]};
          if (st_reg.bit_cnt == ADDR_LAST_BIT)
          begin
            st_next.state = S_DUMMY;
            st_next.fptr = {st_reg.addr_sh[SEC_AW-2:0], st_reg.si_sy[1]};
            st_next.fetching = 1'b1;
            st_next.pend = 1'b0;
          end
        end
        S_DUMMY:
        begin
          if (st_reg.bit_cnt == DUMMY_LAST_BIT)
          begin
            st_next.state = S_DATA;
            st_next.so_oe = 1'b1;
            st_next.out_idx = '0;
          end
        end
        S_DATA, S_SKIP:
          st_next.bit_cnt = st_reg.bit_cnt;
        default:
          st_next.state = S_SKIP;
      endcase
    end
    else if (fall && st_reg.state == S_DATA)
    begin
      st_next.out_idx = st_reg.out_idx + 1'b1;
      if (st_reg.out_idx == 3'h0)
      begin
        st_next.so = buf_out_valid ? buf_out_data[7] : ERASED_BYTE[7];
        st_next.out_sh = {buf_out_data[6:0], 1'b0};
      end
      else
      begin
        st_next.so = st_reg.out_sh[7];
        st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.sclk_sy <= 3'h0;
      st_reg.cs_sy <= 2'h3;
      st_reg.state <= S_CMD;
      st_reg.status <= STATUS_DELIVERY;
    end
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  AST_BAD_CMD_SKIPS: assert property (
    selected && rise && st_reg.state == S_CMD
    && st_reg.bit_cnt == CMD_LAST_BIT
    && {st_reg.in_sh[6:0], st_reg.si_sy[1]} != CMD_RD_SEC
    |=> st_reg.state == S_SKIP ##1 !st_reg.so_oe)
    else $error("wrong command did not skip");

  AST_ADDR_LOADS_PTR: assert property (
    selected && rise && st_reg.state == S_ADDR
    && st_reg.bit_cnt == ADDR_LAST_BIT
    |=> st_reg.fptr == {$past(st_reg.addr_sh[SEC_AW-2:0]),
      $past(st_reg.si_sy[1])} && st_reg.state == S_DUMMY)
    else $error("address not loaded into pointer");

  AST_SO_FALL_ONLY: assert property (
    !(fall && st_reg.state == S_DATA) |=> $stable(st_reg.so))
    else $error("serial output changed off a falling edge");

  AST_PTR_STEP: assert property (
    push && st_reg.fptr != SEC_LAST && selected
    |=> st_reg.fptr == $past(st_reg.fptr) + 10'h001)
    else $error("read pointer did not step by one");

  AST_PTR_WRAP: assert property (
    push && st_reg.fptr == SEC_LAST && selected
    |=> st_reg.fptr == SEC_FIRST)
    else $error("read pointer did not wrap");

  AST_OE_DROPS: assert property (
    !selected |=> !pin_out.so_oe [*2])
    else $error("output still driven after deselect");

  AST_ERASED_READS_FF: assert property (
    push && !st_reg.any_prog |-> mem_q == ERASED_BYTE)
    else $error("erased byte did not read FF");

  AST_STATUS_ZERO: assert property (
    $rose(st_reg.pu_done) |-> status_byte == STATUS_DELIVERY)
    else $error("status not delivered as zero");

  AST_NO_EARLY_WRITE: assert property (
    !st_reg.pu_done |-> !prog_ready)
    else $error("write accepted before power-up delay");

  AST_MSB_FIRST: assert property (
    buf_out_ready && buf_out_valid
    |=> st_reg.so == $past(buf_out_data[7])
    ##0 st_reg.out_sh[7] == $past(buf_out_data[6]))
    else $error("byte not sent most significant bit first");

endmodule

// File: test/srr_host.sv
// Host controller model that runs serial read frames.
`timescale 1ns/1ps
module srr_host (
  // Clock.
  input wire logic mclk,
  // From the device.
  input wire logic so,
  input wire logic so_oe,
  // To the device.
  output srr_pkg::srr_pin_in_s pin
);
  import srr_pkg::*;
  logic [7:0] rx [$];
  logic [15:0] oe_cnt;
  initial pin <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
  task automatic frame(input logic [7:0] cmd, input logic [9:0] a,
    input int n);
    logic [39:0] hdr;
    logic [7:0] b;
    hdr = {cmd, 14'h0000, a, 8'hA5};
    rx.delete();
    oe_cnt = 16'h0000;
    // Half periods of 12 and 13 cycles make the 125 ns link clock.
    @(posedge mclk);
    pin.cs_n <= 1'b0;
    for (int i = 0; i < 40 + 8 * n; i++)
    begin
      pin.sclk <= 1'b0;
      pin.si <= (i < 40) ? hdr[39 - i] : ~pin.si;
      repeat (12) @(posedge mclk);
      pin.sclk <= 1'b1;
      if (i >= 40)
      begin
        b = {b[6:0], so};
        oe_cnt = oe_cnt + 16'(so_oe);
        if (i % 8 == 7)
          rx.push_back(b);
      end
      repeat (13) @(posedge mclk);
    end
    pin.sclk <= 1'b0;
    pin.si <= ~pin.si;
    repeat (13) @(posedge mclk);
    pin.cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// File: test/srr_top_tb.sv
// Self-checking bench of the security area read engine.
`timescale 1ns/1ps
module srr_top_tb;
  import srr_pkg::*;
  logic mclk;
  logic rstn;
  srr_pin_in_s pin_in;
  srr_pin_out_s pin_out;
  srr_prog_s prog;
  logic prog_ready;
  logic [7:0] status_byte;
  logic [7:0] mem [1024];
  logic [9:0] a;
  int bad_count;
  int samples_checked;
  integer seed;
  srr_top #(.PU_CYCLES(50)) DUT (.mclk(mclk), .rstn(rstn),
    .pin_in(pin_in), .pin_out(pin_out), .prog(prog),
    .prog_ready(prog_ready), .status_byte(status_byte));
  srr_host host (.mclk(mclk), .so(pin_out.so), .so_oe(pin_out.so_oe),
    .pin(pin_in));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Expected k-th byte of a read from s, at a wrapping byte address.
  function automatic logic [7:0] exp_rd(input logic [9:0] s, input int k);
    logic [9:0] ix;
    ix = s + k[9:0];
    return mem[ix];
  endfunction
  task automatic pulse(input logic [9:0] pa, input logic [7:0] d);
    prog <= '{valid: 1'b1, addr: pa, data: d};
    @(posedge mclk);
    prog.valid <= 1'b0;
  endtask
  task automatic pgm(input logic [9:0] pa, input logic [7:0] d);
    int w;
    w = 0;
    @(negedge mclk);
    while (prog_ready !== 1'b1 && w < 200)
    begin
      @(negedge mclk);
      w++;
    end
    @(posedge mclk);
    mem[pa] = mem[pa] & d;
    pulse(pa, d);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [9:0] s,
    input int n);
    host.frame(cmd, s, n);
    chk(pin_out.so_oe, 1'b0);
    if (cmd === CMD_RD_SEC)
    begin
      chk(host.oe_cnt, 16'(8 * n));
      for (int k = 0; k < n; k++)
        chk(host.rx[k], exp_rd(s, k));
    end
    else
      chk(host.oe_cnt, 16'h0000);
  endtask
  initial
  begin
    seed = 32'h04e69040;
    bad_count = 0;
    samples_checked = 0;
    rstn <= 1'b0;
    prog <= '0;
    foreach (mem[i])
      mem[i] = 8'hFF;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk(prog_ready, 1'b0);
    pulse(10'h155, 8'h00);
    chk(status_byte, 16'h0000);
    rd(CMD_RD_SEC, 10'h154, 3);
    pgm(10'h3FE, 8'($random(seed)));
    pgm(10'h3FF, 8'($random(seed)));
    pgm(10'h000, 8'($random(seed)));
    pgm(10'h001, 8'($random(seed)));
    rd(CMD_RD_SEC, 10'h3FE, 4);
    fork
      rd(CMD_RD_SEC, 10'h0FF, 2);
      begin
        repeat (200) @(posedge mclk);
        chk(prog_ready, 1'b0);
        pulse(10'h100, 8'h00);
      end
    join
    repeat (8)
    begin
      pgm(10'($random(seed)), 8'($random(seed)));
      a = 10'($random(seed));
      pgm(a, 8'($random(seed)));
      rd(CMD_RD_SEC, a - 10'h001, 1 + ($random(seed) & 7));
    end
    a = 10'($random(seed));
    rd((a[7:0] == 8'h48) ? 8'h0B : a[7:0], a, 2);
    rd(8'h0B, a, 1);
    rd(CMD_RD_SEC, a, 2);
    give_verdict();
  end
  initial
  begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule
